// ---- hw/dcc_defines.vh ----
/*
 * constants of the converter control block: register offsets, field
 * positions, reset values and start-up timing.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// register indices as printed, byte address is four times the index
`define DCC_IDX_CONTROL 8'h00
`define DCC_IDX_CODE 8'h01
`define DCC_ADDR_CONTROL 12'h000
`define DCC_ADDR_CODE 12'h004

// control register fields
`define DCC_BIT_ENABLE 0
`define DCC_BIT_PIN_DRIVE 6
`define DCC_BIT_KEEP_RUN 7
`define DCC_CONTROL_MASK 8'hc1

// reset values
`define DCC_CONTROL_RESET 8'h00
`define DCC_CODE_RESET 8'h00

// analog start-up time after power-up, in ns, and the cycle count at 100 MHz
`define DCC_STARTUP_NS 1000
`define DCC_CLK_PERIOD_NS 10
`define DCC_STARTUP_CYCLES ((`DCC_STARTUP_NS + `DCC_CLK_PERIOD_NS - 1) / `DCC_CLK_PERIOD_NS)

`endif

// ---- hw/dcc_startup_timer.v ----
/*
 * start-up delay counter: counts a fixed number of clocks after start
 * and then raises done until start is withdrawn.
 * assumes mclk at 100 MHz and the constants header.
 */
`timescale 1ns/1ps
`include "dcc_defines.vh"

module dcc_startup_timer (
	mclk,
	reset_n,
	start,
	done
);
	input wire mclk;
	input wire reset_n;
	input wire start;
	output wire done;

	localparam integer cycles_full = `DCC_STARTUP_CYCLES;
	localparam [7:0] cycles = cycles_full[7:0];

	reg [7:0] count_q;

	// count while start is held, clear whenever start is low
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= 8'h00;
		end else if (!start) begin
			count_q <= 8'h00;
		end else if (count_q != cycles) begin
			count_q <= count_q + 8'h01;
		end
	end

	assign done = start && (count_q == cycles);
endmodule

// ---- hw/dcc_control.v ----
/*
 * converter control block: apb register slave, conversion start and
 * power control of the converter and its output buffer in sleep.
 * a code write while running raises the load strobe one edge after the
 * access edge; any power-up converts the stored code once after start-up.
 * the debug halt input is accepted but has no effect on the converter.
 * assumes apb master on mclk, sleep state inputs synchronous to mclk,
 * and the analog converter outside taking code, power and load strobe.
 * assumes the reference is selected elsewhere before enable is set.
 */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "dcc_defines.vh"

module dcc_control (
	mclk,
	reset_n,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	standby_sleep,
	powerdown_sleep,
	clk_per_available,
	debug_halted,
	conv_code,
	conv_power,
	conv_load,
	buffer_power,
	internal_out_valid,
	pin_route
);
	input wire mclk;
	input wire reset_n;
	input wire psel;
	input wire penable;
	input wire pwrite;
	input wire [11:0] paddr;
	input wire [31:0] pwdata;
	output reg [31:0] prdata;
	output wire pready;
	output wire pslverr;
	input wire standby_sleep;
	input wire powerdown_sleep;
	input wire clk_per_available;
	input wire debug_halted;
	output reg [7:0] conv_code;
	output reg conv_power;
	output reg conv_load;
	output reg buffer_power;
	output reg internal_out_valid;
	output reg pin_route;

	// power states, one-hot
	localparam [2:0] st_off = 3'b001;
	localparam [2:0] st_startup = 3'b010;
	localparam [2:0] st_run = 3'b100;

	// register select codes returned by the decoder
	localparam [1:0] sel_none = 2'b00;
	localparam [1:0] sel_control = 2'b01;
	localparam [1:0] sel_code = 2'b10;

	// implemented control bits and their reset values
	localparam [7:0] control_mask = `DCC_CONTROL_MASK;
	localparam [7:0] control_reset = `DCC_CONTROL_RESET;

	// register decode, used for both read and write paths
	function [1:0] dcc_decode;
		input [11:0] addr;
		begin
			dcc_decode = sel_none;
			if (addr == `DCC_ADDR_CONTROL) begin
				dcc_decode = sel_control;
			end else if (addr == `DCC_ADDR_CODE) begin
				dcc_decode = sel_code;
			end
		end
	endfunction

	// true for the state in which conversions may start
	function dcc_running;
		input [2:0] st;
		begin
			dcc_running = (st == st_run);
		end
	endfunction

	// register and state storage
	wire [7:0] control_value;
	reg [7:0] code_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg pending_q;
	reg pending_d;

	// decoded strobes and control terms
	wire access;
	wire wr;
	wire [1:0] sel;
	wire ctl_wr;
	wire code_wr;
	wire enable;
	wire pin_drive;
	wire keep_run;
	wire standby_stop;
	wire sleep_stop;
	wire want_power;
	wire startup_active;
	wire ready_up;
	wire load_now;
	wire run_next;

	// single-cycle access phase qualifiers
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign sel = dcc_decode(paddr);

	// register write strobes
	assign ctl_wr = wr && (sel == sel_control);
	assign code_wr = wr && (sel == sel_code);

	// zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && (sel == sel_none);

	// control fields
	assign enable = control_value[`DCC_BIT_ENABLE];
	assign pin_drive = control_value[`DCC_BIT_PIN_DRIVE];
	assign keep_run = control_value[`DCC_BIT_KEEP_RUN];

	// one flip-flop per implemented control bit, the others read as zero
	genvar bit_i;
	generate
		for (bit_i = 0; bit_i < 8; bit_i = bit_i + 1) begin : g_control
			if (control_mask[bit_i]) begin : g_used
				reg bit_q;
				always @(posedge mclk or negedge reset_n) begin
					if (!reset_n) begin
						bit_q <= control_reset[bit_i];
					end else if (ctl_wr) begin
						bit_q <= pwdata[bit_i];
					end
				end
				assign control_value[bit_i] = bit_q;
			end else begin : g_unused
				assign control_value[bit_i] = 1'b0;
			end
		end
	endgenerate

	// code register, written on the access edge only
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			code_q <= `DCC_CODE_RESET;
		end else if (code_wr) begin
			code_q <= pwdata[7:0];
		end
	end

	// read data, unused bits and unmapped reads give zero
	always @* begin
		case (sel)
			sel_control: begin
				prdata = {24'h000000, control_value};
			end
			sel_code: begin
				prdata = {24'h000000, code_q};
			end
			default: begin
				prdata = 32'h00000000;
			end
		endcase
	end

	// standby stops without keep-run or without the peripheral clock
	assign standby_stop = standby_sleep && (!keep_run || !clk_per_available);
	// power-down always stops
	assign sleep_stop = powerdown_sleep || standby_stop;
	// debug halt is deliberately not a term here
	assign want_power = enable && !sleep_stop;

	// power-up delay before a conversion may follow
	assign startup_active = (state_q == st_startup);
	dcc_startup_timer u_startup (
		.mclk(mclk),
		.reset_n(reset_n),
		.start(startup_active),
		.done(ready_up)
	);

	// power state machine
	always @* begin
		state_d = state_q;
		case (state_q)
			st_off: begin
				if (want_power) begin
					state_d = st_startup;
				end
			end
			st_startup: begin
				if (!want_power) begin
					state_d = st_off;
				end else if (ready_up) begin
					state_d = st_run;
				end
			end
			st_run: begin
				if (!want_power) begin
					state_d = st_off;
				end
			end
			default: begin
				state_d = st_off;
			end
		endcase
	end

	// a conversion starts when running, powered and a request waits
	assign load_now = dcc_running(state_q) && want_power && pending_q;
	assign run_next = dcc_running(state_d);

	// pending request: a new code write wins over the clear of a served one
	always @* begin
		pending_d = pending_q;
		if (code_wr) begin
			pending_d = 1'b1;
		end else if ((state_q == st_off) && want_power) begin
			pending_d = 1'b1;
		end else if (load_now) begin
			pending_d = 1'b0;
		end
	end

	// state and pending request
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= st_off;
			pending_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pending_q <= pending_d;
		end
	end

	// one-cycle conversion strobe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			conv_load <= 1'b0;
		end else begin
			conv_load <= load_now;
		end
	end

	// converter code, latched with each strobe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			conv_code <= `DCC_CODE_RESET;
		end else if (load_now) begin
			conv_code <= code_q;
		end
	end

	// analog power of converter and buffer
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			conv_power <= 1'b0;
			buffer_power <= 1'b0;
		end else begin
			conv_power <= want_power;
			buffer_power <= want_power && pin_drive;
		end
	end

	// output routing to internal users and to the pin
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			internal_out_valid <= 1'b0;
			pin_route <= 1'b0;
		end else begin
			internal_out_valid <= run_next;
			pin_route <= run_next && pin_drive;
		end
	end
endmodule

// ---- test/dcc_control_monitor.sv ----
/* port checker of the converter control block.
   assumes a bind onto dcc_control, outputs registered on mclk. */
`timescale 1ns/1ps
module dcc_control_monitor (
	input wire mclk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire standby_sleep,
	input wire powerdown_sleep,
	input wire clk_per_available,
	input wire debug_halted,
	input wire [7:0] conv_code,
	input wire conv_power,
	input wire conv_load,
	input wire buffer_power,
	input wire internal_out_valid,
	input wire pin_route
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// access phase of a transfer
	wire acc = psel && penable;
	// code write while running awake
	sequence s_code_wr;
		acc && pwrite && paddr == 12'h004 && internal_out_valid && !standby_sleep && !powerdown_sleep;
	endsequence
	// control write that clears the enable bit
	sequence s_ctl_off;
		acc && pwrite && paddr == 12'h000 && !pwdata[0];
	endsequence
	a_code_load: assert property (s_code_wr |-> ##2 conv_load && conv_code == $past(pwdata[7:0], 2))
		else $error("code write did not load");
	a_load_power: assert property (conv_load |-> conv_power && internal_out_valid)
		else $error("load while unpowered");
	a_ctl_off: assert property (s_ctl_off |-> ##[1:2] !conv_power)
		else $error("converter stayed on");
	a_startup_wait: assert property ($rose(conv_power) |-> !internal_out_valid [*8])
		else $error("output valid without start-up");
	a_valid_power: assert property (internal_out_valid |-> conv_power)
		else $error("output valid while off");
	a_route_buffer: assert property (pin_route |-> buffer_power)
		else $error("pin routed without buffer");
	a_powerdown_off: assert property (powerdown_sleep [*2] |-> !conv_power && !buffer_power)
		else $error("powered in power-down");
	a_standby_stop: assert property ((standby_sleep && !clk_per_available) [*2] |-> !conv_power)
		else $error("powered in standby without clock");
	a_ctl_read: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0 && prdata[5:1] == 5'h0)
		else $error("unused control bits read set");
	// code write while the converter is off
	sequence s_code_wr_off;
		acc && pwrite && paddr == 12'h004 && !conv_power;
	endsequence
	// debug halt entered
	sequence s_debug_entry;
		$rose(debug_halted);
	endsequence
	a_store_only: assert property (s_code_wr_off |-> ##1 !conv_load ##1 !conv_load)
		else $error("code write converted while off");
	a_debug_keep: assert property (s_debug_entry |=> $stable(conv_power) && $stable(buffer_power))
		else $error("debug entry changed converter power");
endmodule

// ---- test/dcc_control_tb.sv ----
/* self-checking bench of the converter control block.
   assumes dcc_control with zero wait apb and fixed start-up. */
`timescale 1ns/1ps
module dcc_control_tb;
	logic mclk = 0;
	logic reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic standby_sleep = 0, powerdown_sleep = 0, clk_per_available = 1, debug_halted = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic pready, pslverr, perr, conv_power, conv_load, buffer_power, internal_out_valid, pin_route;
	logic [7:0] conv_code;
	int errors = 0, num_checks = 0;
	dcc_control u_dut (
		.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep),
		.clk_per_available(clk_per_available), .debug_halted(debug_halted),
		.conv_code(conv_code), .conv_power(conv_power), .conv_load(conv_load),
		.buffer_power(buffer_power), .internal_out_valid(internal_out_valid),
		.pin_route(pin_route)
	);
	// clock of 10 ns
	always #5 mclk = ~mclk;
	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one apb transfer, read data and error kept
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin
			errors++;
		end
		rdata = prdata;
		perr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// wait for a conversion start pulse
	task wl;
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge mclk);
			if (conv_load === 1'b1) break;
		end
		if (n == 300) begin
			errors++;
		end
	endtask
	// main sequence
	initial begin
		cyc(5);
		reset_n <= 1;
		apb(0, 12'h000, 0); check(rdata, 32'h0);
		apb(0, 12'h004, 0); check(rdata, 32'h0);
		apb(1, 12'h000, 32'h40);
		apb(1, 12'h004, 32'h5a);
		cyc(20); check({conv_power, buffer_power}, 2'h0);
		apb(1, 12'h000, 32'hff);
		apb(0, 12'h000, 0); check(rdata, 32'hc1);
		wl; check(conv_code, 8'h5a);
		check({buffer_power, pin_route, internal_out_valid}, 3'h7);
		$display("test 1 done");
		apb(1, 12'h004, 32'ha5);
		wl; check(conv_code, 8'ha5);
		apb(0, 12'h004, 0); check(rdata, 32'ha5);
		debug_halted <= 1;
		apb(1, 12'h004, 32'h3c);
		wl; check(conv_code, 8'h3c);
		$display("test 2 done");
		standby_sleep <= 1;
		cyc(20); check(conv_power, 1'b1);
		clk_per_available <= 0;
		cyc(5); check(conv_power, 1'b0);
		standby_sleep <= 0;
		clk_per_available <= 1;
		apb(1, 12'h000, 32'h41);
		standby_sleep <= 1;
		cyc(5); check({conv_power, buffer_power}, 2'h0);
		standby_sleep <= 0;
		wl; check({conv_code, buffer_power}, 9'h079);
		$display("test 3 done");
		apb(1, 12'h000, 32'hc1);
		powerdown_sleep <= 1;
		cyc(5); check({conv_power, buffer_power}, 2'h0);
		powerdown_sleep <= 0;
		wl;
		apb(1, 12'h000, 32'h01);
		cyc(3); check({pin_route, internal_out_valid}, 2'h1);
		apb(1, 12'h000, 32'h00);
		cyc(3); check(conv_power, 1'b0);
		apb(1, 12'h008, 32'hff);
		apb(0, 12'h008, 0); check(rdata, 32'h0);
		check(perr, 1'b1);
		$display("test 4 done");
		apb(1, 12'h000, 32'hc0);
		reset_n <= 0;
		cyc(2);
		reset_n <= 1;
		apb(0, 12'h004, 0); check(rdata, 32'h0);
		apb(0, 12'h000, 0); check(rdata, 32'h0);
		$display("test 5 done");
		results;
	end
endmodule
bind dcc_control dcc_control_monitor u_mon (
	.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .standby_sleep(standby_sleep),
	.powerdown_sleep(powerdown_sleep), .clk_per_available(clk_per_available),
	.debug_halted(debug_halted), .conv_code(conv_code), .conv_power(conv_power),
	.conv_load(conv_load), .buffer_power(buffer_power),
	.internal_out_valid(internal_out_valid), .pin_route(pin_route)
);
